// ==== src/tqr_pkg.sv ====
// Constants for the transmit queue ratio control register bank.
// Assumes a 16-bit register port addressed by byte offset.
package tqr_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int RATIO_W  = 7;
  localparam int NUM_Q    = 4;
  localparam int QIDX_W   = 2;
  localparam int FIELD_W  = 8;

  // Register offsets
  localparam logic [7:0] ADDR_P1_UPPER = 8'hc8;
  localparam logic [7:0] ADDR_P1_LOWER = 8'hca;
  localparam logic [7:0] ADDR_P2_UPPER = 8'hcc;
  localparam logic [7:0] ADDR_P2_LOWER = 8'hce;
  localparam logic [7:0] ADDR_P1_STAT  = 8'hf0;
  localparam logic [7:0] ADDR_P2_STAT  = 8'hf2;

  // Reset values: control bits set, ratios 4/8 and 1/2
  localparam logic [15:0] UPPER_RESET = 16'h8488;
  localparam logic [15:0] LOWER_RESET = 16'h8182;

  // Field layout: control bit inside a byte lane, and the byte lane offsets
  localparam int CTRL_BIT  = 7;
  localparam int HI_LANE   = 8;
  localparam int LO_LANE   = 0;

  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;
endpackage

// ==== src/tqr_regs.sv ====
// Ratio control registers and per-port transmit queue schedulers.
// Assumes a plain register port and one pick request per packet slot.
//
// Notes on behaviour
// - First register per port: queue 2 in upper byte, queue 3 lower.
// - Second register per port: queue 0 in upper byte, queue 1 lower.
// - Port 2 has its own identical pair acting only on its queues.
// - Queue 2 control clear: queue 2 drains before lower queues.
// - Queue 3 control clear: queue 3 drains before all lower queues.
// - Queue 0 control clear: served only after higher queues.
// - Queue 1 control clear: queue 1 drains before queue 0.
// - Upper control set: queue limited to bits 14:8 packets per period.
// - Lower control set: queue limited to bits 6:0 packets per period.
// - Reset: queue 3 ratio 8, queue 2 ratio 4.
// - Reset: queue 1 ratio 2, queue 0 ratio 1.
// - All control bits reset to one; every field read/write.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module tqr_port_sched (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Configuration
  input  wire logic [15:0] upper_reg,
  input  wire logic [15:0] lower_reg,
  // Scheduling
  input  wire logic        period_start,
  input  wire logic [3:0]  pending,
  input  wire logic        pick,
  output logic             grant,
  output logic [1:0]       grant_queue,
  output logic [3:0]       exhausted
);

  // Byte lane of queue q: q3 upper lo, q2 upper hi, q1 lower lo, q0 lower hi
  function automatic logic [7:0] field_of(input logic [15:0] up,
                                          input logic [15:0] lo,
                                          input int          q);
    logic [7:0] f;
    f = 8'h00;
    case (q)
      3:       f = up[tqr_pkg::LO_LANE +: tqr_pkg::FIELD_W];
      2:       f = up[tqr_pkg::HI_LANE +: tqr_pkg::FIELD_W];
      1:       f = lo[tqr_pkg::LO_LANE +: tqr_pkg::FIELD_W];
      default: f = lo[tqr_pkg::HI_LANE +: tqr_pkg::FIELD_W];
    endcase
    return f;
  endfunction

  logic [3:0] ctrl;
  logic [3:0] elig;
  logic [6:0] ratio  [4];
  logic [6:0] credit [4];
  logic [6:0] next_credit [4];
  logic [1:0] sel;
  logic       any;
  logic       take;

  for (genvar q = 0; q < tqr_pkg::NUM_Q; q++) begin : g_q
    localparam logic [7:0] RST_F =
      field_of(tqr_pkg::UPPER_RESET, tqr_pkg::LOWER_RESET, q);
    localparam int QN = q;
    localparam logic [tqr_pkg::QIDX_W-1:0] QIDX = QN[tqr_pkg::QIDX_W-1:0];
    wire logic [7:0] f = field_of(upper_reg, lower_reg, q);
    assign ctrl[q]  = f[tqr_pkg::CTRL_BIT];
    assign ratio[q] = f[tqr_pkg::RATIO_W-1:0];
    // Strict queues eligible whenever pending; ratio queues only with credit
    assign elig[q]  = pending[q] && (!ctrl[q] || credit[q] != 7'h00);
    // Period reload wins over a same-cycle decrement
    assign next_credit[q] =
      period_start ? ratio[q] :
      (take && sel == QIDX && ctrl[q] && credit[q] != 7'h00)
        ? credit[q] - 7'h01 : credit[q];

    always_ff @(posedge mclk) begin
      if (!rstn) begin
        credit[q]    <= RST_F[tqr_pkg::RATIO_W-1:0];
        exhausted[q] <= 1'b0;
      end else begin
        credit[q]    <= next_credit[q];
        exhausted[q] <= ctrl[q] && next_credit[q] == 7'h00;
      end
    end

    property p_reload;
      @(posedge mclk) disable iff (!rstn)
        period_start |=> credit[q] == $past(ratio[q]);
    endproperty
    a_reload: assert property (p_reload)
      else $error("credit not reloaded at period start");

    property p_decrement;
      @(posedge mclk) disable iff (!rstn)
        !period_start && take && sel == QIDX && ctrl[q]
        |=> credit[q] == $past(credit[q]) - 7'h01;
    endproperty
    a_decrement: assert property (p_decrement)
      else $error("ratio queue credit not spent on grant");
  end

  // Highest eligible queue wins
  assign sel  = elig[3] ? tqr_pkg::Q3 :
                elig[2] ? tqr_pkg::Q2 :
                elig[1] ? tqr_pkg::Q1 : tqr_pkg::Q0;
  assign any  = |elig;
  assign take = pick && any;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      grant       <= 1'b0;
      grant_queue <= tqr_pkg::Q0;
    end else begin
      grant       <= take;
      grant_queue <= sel;
    end
  end

  property p_q3_strict;
    @(posedge mclk) disable iff (!rstn)
      pick && pending[3] && !ctrl[3] |=> grant && grant_queue == 2'h3;
  endproperty
  a_q3_strict: assert property (p_q3_strict)
    else $error("strict queue 3 not served first");

  property p_q2_strict;
    @(posedge mclk) disable iff (!rstn)
      pick && pending[2] && !ctrl[2] && !elig[3]
      |=> grant && grant_queue == 2'h2;
  endproperty
  a_q2_strict: assert property (p_q2_strict)
    else $error("strict queue 2 passed over");

  property p_q1_strict;
    @(posedge mclk) disable iff (!rstn)
      pick && pending[1] && !ctrl[1] && !elig[3] && !elig[2]
      |=> grant && grant_queue == 2'h1;
  endproperty
  a_q1_strict: assert property (p_q1_strict)
    else $error("strict queue 1 not served before queue 0");

  property p_q0_last;
    @(posedge mclk) disable iff (!rstn)
      grant && grant_queue == 2'h0 |-> $past(elig[3:1]) == 3'h0;
  endproperty
  a_q0_last: assert property (p_q0_last)
    else $error("queue 0 served ahead of an eligible higher queue");

  property p_spent_blocks;
    @(posedge mclk) disable iff (!rstn)
      pick && !pending[3] && !pending[2] && !pending[1] && pending[0]
      && ctrl[0] && credit[0] == 7'h00 |=> !grant;
  endproperty
  a_spent_blocks: assert property (p_spent_blocks)
    else $error("spent ratio queue was granted");

endmodule

////////////////////////////////////////////////////////////////////////////
module tqr_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Scheduling period
  input  wire logic        period_start,
  // Port 1 transmit queues
  input  wire logic [3:0]  p1_pending,
  input  wire logic        p1_pick,
  output logic             p1_grant,
  output logic      [1:0]  p1_grant_queue,
  // Port 2 transmit queues
  input  wire logic [3:0]  p2_pending,
  input  wire logic        p2_pick,
  output logic             p2_grant,
  output logic      [1:0]  p2_grant_queue
);

  logic [15:0] port1_upper_queue_ratio;
  logic [15:0] port1_lower_queue_ratio;
  logic [15:0] port2_upper_queue_ratio;
  logic [15:0] port2_lower_queue_ratio;
  logic [3:0]  p1_exhausted;
  logic [3:0]  p2_exhausted;
  logic [15:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // Write decode
  wire logic wr_p1u = reg_wr && reg_addr == tqr_pkg::ADDR_P1_UPPER;
  wire logic wr_p1l = reg_wr && reg_addr == tqr_pkg::ADDR_P1_LOWER;
  wire logic wr_p2u = reg_wr && reg_addr == tqr_pkg::ADDR_P2_UPPER;
  wire logic wr_p2l = reg_wr && reg_addr == tqr_pkg::ADDR_P2_LOWER;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      port1_upper_queue_ratio <= tqr_pkg::UPPER_RESET;
      port1_lower_queue_ratio <= tqr_pkg::LOWER_RESET;
      port2_upper_queue_ratio <= tqr_pkg::UPPER_RESET;
      port2_lower_queue_ratio <= tqr_pkg::LOWER_RESET;
    end else begin
      if (wr_p1u) port1_upper_queue_ratio <= reg_wdata;
      if (wr_p1l) port1_lower_queue_ratio <= reg_wdata;
      if (wr_p2u) port2_upper_queue_ratio <= reg_wdata;
      if (wr_p2l) port2_lower_queue_ratio <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  assign rd_mux =
    reg_addr == tqr_pkg::ADDR_P1_UPPER ? port1_upper_queue_ratio :
    reg_addr == tqr_pkg::ADDR_P1_LOWER ? port1_lower_queue_ratio :
    reg_addr == tqr_pkg::ADDR_P2_UPPER ? port2_upper_queue_ratio :
    reg_addr == tqr_pkg::ADDR_P2_LOWER ? port2_lower_queue_ratio :
    reg_addr == tqr_pkg::ADDR_P1_STAT  ? {12'h000, p1_exhausted} :
    reg_addr == tqr_pkg::ADDR_P2_STAT  ? {12'h000, p2_exhausted} :
    16'h0000;

  always_ff @(posedge mclk) begin
    if (!rstn) reg_rdata <= 16'h0000;
    else       reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // One scheduler per port, each steered only by its own pair
  tqr_port_sched u_p1 (
    .mclk         (mclk),
    .rstn         (rstn),
    .upper_reg    (port1_upper_queue_ratio),
    .lower_reg    (port1_lower_queue_ratio),
    .period_start (period_start),
    .pending      (p1_pending),
    .pick         (p1_pick),
    .grant        (p1_grant),
    .grant_queue  (p1_grant_queue),
    .exhausted    (p1_exhausted)
  );

  tqr_port_sched u_p2 (
    .mclk         (mclk),
    .rstn         (rstn),
    .upper_reg    (port2_upper_queue_ratio),
    .lower_reg    (port2_lower_queue_ratio),
    .period_start (period_start),
    .pending      (p2_pending),
    .pick         (p2_pick),
    .grant        (p2_grant),
    .grant_queue  (p2_grant_queue),
    .exhausted    (p2_exhausted)
  );

  //////////////////////////////////////////////////////////////////////////
  property p_reset_values;
    @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> port1_upper_queue_ratio == tqr_pkg::UPPER_RESET
                   && port1_lower_queue_ratio == tqr_pkg::LOWER_RESET
                   && port2_upper_queue_ratio == tqr_pkg::UPPER_RESET
                   && port2_lower_queue_ratio == tqr_pkg::LOWER_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("ratio registers wrong after reset");

  property p_write_read;
    @(posedge mclk) disable iff (!rstn)
      reg_wr && reg_addr == tqr_pkg::ADDR_P1_LOWER
      ##1 reg_rd && reg_addr == tqr_pkg::ADDR_P1_LOWER && !reg_wr
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("written ratio value not read back");

  property p_read_upper;
    @(posedge mclk) disable iff (!rstn)
      reg_rd && reg_addr == tqr_pkg::ADDR_P1_UPPER
      |=> reg_rdata == $past(port1_upper_queue_ratio);
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("upper ratio register read wrong");

  property p_port_isolation;
    @(posedge mclk) disable iff (!rstn)
      reg_wr && reg_addr == tqr_pkg::ADDR_P2_UPPER
      |=> port1_upper_queue_ratio == $past(port1_upper_queue_ratio)
       && port2_upper_queue_ratio == $past(reg_wdata);
  endproperty
  a_port_isolation: assert property (p_port_isolation)
    else $error("port 2 write disturbed port 1");

  property p_lower_isolation;
    @(posedge mclk) disable iff (!rstn)
      reg_wr && reg_addr == tqr_pkg::ADDR_P2_LOWER
      |=> port1_lower_queue_ratio == $past(port1_lower_queue_ratio)
       && port2_lower_queue_ratio == $past(reg_wdata);
  endproperty
  a_lower_isolation: assert property (p_lower_isolation)
    else $error("port 2 lower write disturbed port 1");

  property p_rdata_idle;
    @(posedge mclk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the transmit queue ratio control register bank.
// Assumes tqr_regs from src/ and the constants of tqr_pkg.
`timescale 1ns/1ps

module tb_top;
  // Clock and reset
  logic        mclk         = 1'b0;
  logic        rstn         = 1'b0;
  // Register port
  logic [7:0]  reg_addr     = 8'h00;
  logic [15:0] reg_wdata    = 16'h0000;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [15:0] reg_rdata;
  // Scheduling
  logic        period_start = 1'b0;
  logic [3:0]  p1_pending   = 4'h0;
  logic [3:0]  p2_pending   = 4'h0;
  logic        p1_pick      = 1'b0;
  logic        p2_pick      = 1'b0;
  logic        p1_grant;
  logic        p2_grant;
  logic [1:0]  p1_grant_queue;
  logic [1:0]  p2_grant_queue;
  int          n_fail       = 0;
  int          checks       = 0;

  always #25 mclk = ~mclk;

  tqr_regs dut_u (
    .mclk(mclk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .period_start(period_start),
    .p1_pending(p1_pending), .p1_pick(p1_pick),
    .p1_grant(p1_grant), .p1_grant_queue(p1_grant_queue),
    .p2_pending(p2_pending), .p2_pick(p2_pick),
    .p2_grant(p2_grant), .p2_grant_queue(p2_grant_queue)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask

  // Write then read back with no gap between the strobes
  task automatic wr_rd(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    #1 chk("reg_rdata", d, reg_rdata);
  endtask

  task automatic tick();
    @(posedge mclk);
    period_start <= 1'b1;
    @(posedge mclk);
    period_start <= 1'b0;
  endtask

  // One pick; the grant is looked at in the cycle after the pick edge
  task automatic pick(int p, logic g, logic [1:0] q);
    @(posedge mclk);
    if (p == 1) begin
      p1_pick <= 1'b1;
    end else begin
      p2_pick <= 1'b1;
    end
    @(posedge mclk);
    p1_pick <= 1'b0;
    p2_pick <= 1'b0;
    #1;
    if (p == 1) begin
      chk("p1_grant", {15'h0000, g}, {15'h0000, p1_grant});
      if (g) chk("p1_grant_queue", {14'h0000, q}, {14'h0000, p1_grant_queue});
    end else begin
      chk("p2_grant", {15'h0000, g}, {15'h0000, p2_grant});
      if (g) chk("p2_grant_queue", {14'h0000, q}, {14'h0000, p2_grant_queue});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(tqr_pkg::ADDR_P1_UPPER, 16'h8488);
    rd(tqr_pkg::ADDR_P1_LOWER, 16'h8182);
    rd(tqr_pkg::ADDR_P2_UPPER, 16'h8488);
    rd(tqr_pkg::ADDR_P2_LOWER, 16'h8182);
    rd(8'hc9, 16'h0000);
  endtask

  task automatic t_rw();
    wr(tqr_pkg::ADDR_P1_UPPER, 16'h7f7f);
    wr(tqr_pkg::ADDR_P2_LOWER, 16'h0a05);
    wr(tqr_pkg::ADDR_P2_UPPER, 16'h1122);
    wr(tqr_pkg::ADDR_P1_STAT, 16'hffff);
    rd(tqr_pkg::ADDR_P1_UPPER, 16'h7f7f);
    rd(tqr_pkg::ADDR_P2_LOWER, 16'h0a05);
    rd(tqr_pkg::ADDR_P1_LOWER, 16'h8182);
    rd(tqr_pkg::ADDR_P2_UPPER, 16'h1122);
    rd(tqr_pkg::ADDR_P1_STAT, 16'h0000);
    wr_rd(tqr_pkg::ADDR_P1_LOWER, 16'h3c5a);
    wr(tqr_pkg::ADDR_P1_UPPER, tqr_pkg::UPPER_RESET);
    wr(tqr_pkg::ADDR_P2_UPPER, tqr_pkg::UPPER_RESET);
    wr(tqr_pkg::ADDR_P1_LOWER, tqr_pkg::LOWER_RESET);
    wr(tqr_pkg::ADDR_P2_LOWER, tqr_pkg::LOWER_RESET);
  endtask

  // Queue 3 spends 8, queue 0 spends 1, then nothing until reload
  task automatic t_ratio();
    p1_pending <= 4'b1001;
    p2_pending <= 4'b1000;
    tick();
    for (int i = 0; i < 8; i++) pick(1, 1'b1, tqr_pkg::Q3);
    pick(1, 1'b1, tqr_pkg::Q0);
    pick(1, 1'b0, tqr_pkg::Q0);
    p1_pending <= 4'b0001;
    pick(1, 1'b0, tqr_pkg::Q0);
    rd(tqr_pkg::ADDR_P1_STAT, 16'h0009);
    p1_pending <= 4'b1001;
    pick(2, 1'b1, tqr_pkg::Q3);
    tick();
    pick(1, 1'b1, tqr_pkg::Q3);
  endtask

  // Strict queue keeps winning well past its ratio
  task automatic t_strict(logic [7:0] a, logic [15:0] v, logic [3:0] pend,
                          logic [1:0] q);
    logic [15:0] rst_v;
    rst_v = (a == tqr_pkg::ADDR_P1_UPPER) ? tqr_pkg::UPPER_RESET
                                          : tqr_pkg::LOWER_RESET;
    wr(a, v);
    p1_pending <= pend;
    tick();
    repeat (12) pick(1, 1'b1, q);
    wr(a, rst_v);
  endtask

  // Mid-run reset puts registers and credits back to their reset values
  task automatic t_rerst();
    wr(tqr_pkg::ADDR_P2_LOWER, 16'h1234);
    p1_pending <= 4'b1000;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(tqr_pkg::ADDR_P2_LOWER, tqr_pkg::LOWER_RESET);
    for (int i = 0; i < 8; i++) pick(1, 1'b1, tqr_pkg::Q3);
    pick(1, 1'b0, tqr_pkg::Q3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_rw();
    t_ratio();
    t_strict(tqr_pkg::ADDR_P1_UPPER, 16'h8408, 4'b1001, tqr_pkg::Q3);
    t_strict(tqr_pkg::ADDR_P1_UPPER, 16'h0488, 4'b0101, tqr_pkg::Q2);
    t_strict(tqr_pkg::ADDR_P1_LOWER, 16'h8102, 4'b0011, tqr_pkg::Q1);
    t_strict(tqr_pkg::ADDR_P1_LOWER, 16'h0182, 4'b0001, tqr_pkg::Q0);
    t_rerst();
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    wrap_up();
  end
endmodule
